// file: logic/dld_directional_loop_decision.sv
// Directional front end: fault loop choice, angle decision, current routing.
// Assumes an APB master on pclk, measurements from same-clock logic, and
// asynchronous switch-onto-fault and VT failure pins.
// Operation
// RQ1: Solid earth: smallest impedance among six loops.
// RQ2: Loop needs voltage above 5%, current 8%.
// RQ3: Isolated network uses phase-to-phase loops only.
// RQ4: Network type defaults solid; isolated for compensated.
// RQ5: Enable only when voltage and current suffice.
// RQ6: Angle of loop voltage against loop current.
// RQ7: Direction true when angle inside window.
// RQ8: Operating angle 10 to 85, default 60.
// RQ9: Characteristic angle -90 to 90, default 60.
// RQ10: Forward, backward or non-directional; polarity counts.
// RQ11: Low loop voltage: use positive-sequence voltage.
// RQ12: Positive sequence too low: use stored voltages.
// RQ13: Switch-onto-fault forces direction true, no delay.
// RQ14: VT failure with fallback: act non-directionally.
// RQ15: VT failure without fallback blocks the function.
// RQ16: Non-directional setting makes direction true.
// RQ17: Route fundamental or RMS currents, fundamental default.
// RQ18: Enables combine by AND before angle check.
// RQ19: Overcurrent released only while direction true.
// RQ20: Window is centre angle plus/minus width; backward turns.
`timescale 1ns/1ps
module dld_directional_loop_decision
    import dld_pkg::*;
(
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic [11:0]                        paddr,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic [DLD_NLOOP-1:0][DLD_W-1:0]    loop_u_mag,
    input  wire logic [DLD_NLOOP-1:0][DLD_AW-1:0]   loop_u_ang,
    input  wire logic [DLD_NLOOP-1:0][DLD_W-1:0]    loop_i_mag,
    input  wire logic [DLD_NLOOP-1:0][DLD_AW-1:0]   loop_i_ang,
    input  wire logic [DLD_W-1:0]                   pos_u_mag,
    input  wire logic signed [DLD_AW-1:0]           pos_u_ang,
    input  wire logic [2:0][DLD_W-1:0]              i_fund,
    input  wire logic [2:0][DLD_W-1:0]              i_rms,
    input  wire logic                               switch_onto_fault_cond,
    input  wire logic                               vt_supervision_fail,
    output logic                                    direction_ok,
    output logic                                    oc_release,
    output logic      [2:0][DLD_W-1:0]              oc_current
);
    typedef enum logic {DLD_SCAN, DLD_DECIDE} dld_state_e;

    typedef struct packed {
        dld_state_e                             st;
        logic [2:0]                             idx;
        logic [2:0]                             best;
        logic [2:0]                             sel;
        logic                                   found;
        logic                                   best_uok;
        logic                                   iso_l;
        logic                                   iso;
        logic [1:0]                             dir;
        logic                                   vtnd;
        logic                                   rms;
        logic                                   uinv;
        logic                                   iinv;
        logic                                   en;
        logic [6:0]                             roa;
        logic signed [7:0]                      rca;
        logic [DLD_W-1:0]                       u_rat;
        logic [DLD_W-1:0]                       i_rat;
        logic                                   sotf_m;
        logic                                   sotf_s;
        logic                                   vtf_m;
        logic                                   vtf_s;
        logic [DLD_NLOOP-1:0][DLD_AW-1:0]       mem_ang;
        logic [DLD_NLOOP-1:0]                   mem_ok;
        logic                                   dir_ok;
        logic                                   dir_en;
        logic                                   blk;
        logic                                   rel;
        logic [DLD_AW-1:0]                      angle;
        logic [1:0]                             src;
        logic [31:0]                            prdata;
        logic                                   pready;
        logic                                   pslverr;
        logic [2:0][DLD_W-1:0]                  oc_cur;
    } dld_state_s;

    dld_state_s               q;
    dld_state_s               n;
    logic [DLD_NLOOP-1:0]     u_ok;
    logic [DLD_NLOOP-1:0]     i_ok;
    logic                     pos_ok;
    logic                     allowed;
    logic                     z_less;
    logic                     take;
    logic [1:0]               src_c;
    logic signed [DLD_AW-1:0] u_ang_c;
    logic signed [DLD_AW-1:0] ang_c;
    logic                     in_win;
    logic                     non_directional_c;
    logic                     blk_c;
    logic                     dir_en_c;
    logic                     wr_acc;
    logic                     hit;
    logic [6:0]               roa_w;
    logic signed [7:0]        rca_w;

    dld_loop_qualify #(.N(DLD_NLOOP)) u_qual (
        .u_mag   (loop_u_mag),
        .i_mag   (loop_i_mag),
        .u_rated (q.u_rat),
        .i_rated (q.i_rat),
        .u_ok    (u_ok),
        .i_ok    (i_ok)
    );

    dld_loop_qualify #(.N(1)) u_pos (
        .u_mag   (pos_u_mag),
        .i_mag   (pos_u_mag),
        .u_rated (q.u_rat),
        .i_rated (q.i_rat),
        .u_ok    (pos_ok),
        .i_ok    ()
    );

    dld_angle_window u_win (
        .angle    (ang_c),
        .rca      (q.rca),
        .roa      (q.roa),
        .backward (q.dir == DLD_DIR_BWD),
        .flip     (q.uinv ^ q.iinv),
        .in_win   (in_win)
    );

    // Impedances are compared by cross products, so no divider is needed.
    assign allowed = !q.iso_l || (q.idx < 3'(DLD_NPP)); // RQ3 RQ1
    assign z_less  = 32'(loop_u_mag[q.idx]) * 32'(loop_i_mag[q.best])
                   < 32'(loop_u_mag[q.best]) * 32'(loop_i_mag[q.idx]);
    // A loop that meets the voltage level beats one that does not.
    assign take = allowed && i_ok[q.idx] // RQ2
               && (!q.found || (u_ok[q.idx] && !q.best_uok)
                   || (u_ok[q.idx] == q.best_uok && z_less)); // RQ1

    assign src_c = u_ok[q.best]      ? DLD_SRC_LOOP :
                   pos_ok            ? DLD_SRC_POS  : // RQ11
                   q.mem_ok[q.best]  ? DLD_SRC_MEM  : // RQ12
                                       DLD_SRC_NONE;
    assign u_ang_c = (src_c == DLD_SRC_POS) ? pos_u_ang :
                     (src_c == DLD_SRC_MEM) ? q.mem_ang[q.best] :
                                              loop_u_ang[q.best];
    assign ang_c = dld_wrap(12'(u_ang_c)
                 - 12'(signed'(loop_i_ang[q.best]))); // RQ6
    assign dir_en_c = q.found && (src_c != DLD_SRC_NONE); // RQ5 RQ18
    assign blk_c    = q.vtf_s && !q.vtnd; // RQ15
    assign non_directional_c = (q.dir == DLD_DIR_NON_DIRECTIONAL)
                   || (q.vtf_s && q.vtnd); // RQ16 RQ14

    assign wr_acc = psel && penable && pwrite && q.pready;
    assign hit    = paddr == DLD_OFF_CTRL || paddr == DLD_OFF_ANGLE
                 || paddr == DLD_OFF_RATED || paddr == DLD_OFF_STATUS;
    assign roa_w  = pwdata[DLD_ROA_LSB +: 7];
    assign rca_w  = pwdata[DLD_RCA_LSB +: 8];

    always_comb
    begin
        n = q;
        n.sotf_m = switch_onto_fault_cond;
        n.sotf_s = q.sotf_m;
        n.vtf_m  = vt_supervision_fail;
        n.vtf_s  = q.vtf_m;
        n.oc_cur = q.rms ? i_rms : i_fund; // RQ17
        n.pready = psel && !penable && !q.pready;
        if (psel && !penable)
        begin
            n.pslverr = !hit;
            n.prdata  = 32'h00000000;
            case (paddr)
                DLD_OFF_CTRL:
                begin
                    n.prdata[DLD_CTL_ISO]      = q.iso;
                    n.prdata[DLD_CTL_DIR +: 2] = q.dir;
                    n.prdata[DLD_CTL_VTND]     = q.vtnd;
                    n.prdata[DLD_CTL_RMS]      = q.rms;
                    n.prdata[DLD_CTL_UINV]     = q.uinv;
                    n.prdata[DLD_CTL_IINV]     = q.iinv;
                    n.prdata[DLD_CTL_EN]       = q.en;
                end
                DLD_OFF_ANGLE:
                begin
                    n.prdata[DLD_ROA_LSB +: 7] = q.roa;
                    n.prdata[DLD_RCA_LSB +: 8] = q.rca;
                end
                DLD_OFF_RATED:
                begin
                    n.prdata[DLD_URAT_LSB +: DLD_W] = q.u_rat;
                    n.prdata[DLD_IRAT_LSB +: DLD_W] = q.i_rat;
                end
                DLD_OFF_STATUS:
                begin
                    n.prdata[DLD_ST_OK]            = q.dir_ok;
                    n.prdata[DLD_ST_EN]            = q.dir_en;
                    n.prdata[DLD_ST_LOOP +: 3]     = q.sel;
                    n.prdata[DLD_ST_SRC +: 2]      = q.src;
                    n.prdata[DLD_ST_BLK]           = q.blk;
                    n.prdata[DLD_ST_ANG +: DLD_AW] = q.angle;
                end
                default: n.prdata = 32'h00000000;
            endcase
        end
        if (wr_acc)
        begin
            case (paddr)
                DLD_OFF_CTRL:
                begin
                    n.iso  = pwdata[DLD_CTL_ISO]; // RQ4
                    n.dir  = pwdata[DLD_CTL_DIR +: 2]; // RQ10
                    n.vtnd = pwdata[DLD_CTL_VTND];
                    n.rms  = pwdata[DLD_CTL_RMS];
                    n.uinv = pwdata[DLD_CTL_UINV];
                    n.iinv = pwdata[DLD_CTL_IINV];
                    n.en   = pwdata[DLD_CTL_EN];
                end
                DLD_OFF_ANGLE:
                begin
                    // Out-of-range settings are dropped, the old one stays.
                    if (roa_w >= DLD_ROA_MIN && roa_w <= DLD_ROA_MAX)
                        n.roa = roa_w; // RQ8
                    if (rca_w >= DLD_RCA_MIN && rca_w <= DLD_RCA_MAX)
                        n.rca = rca_w; // RQ9
                end
                DLD_OFF_RATED:
                begin
                    n.u_rat = pwdata[DLD_URAT_LSB +: DLD_W];
                    n.i_rat = pwdata[DLD_IRAT_LSB +: DLD_W];
                end
                default: n.en = q.en;
            endcase
        end
        case (q.st)
            DLD_SCAN:
            begin
                // Only healthy voltages are kept, so memory holds pre-fault.
                if (u_ok[q.idx])
                begin
                    n.mem_ang[q.idx] = loop_u_ang[q.idx]; // RQ12
                    n.mem_ok[q.idx]  = 1'b1;
                end
                if (take)
                begin
                    n.best     = q.idx;
                    n.found    = 1'b1;
                    n.best_uok = u_ok[q.idx];
                end
                if (q.idx == 3'(DLD_NLOOP - 1))
                    n.st = DLD_DECIDE;
                else
                    n.idx = q.idx + 3'h1;
            end
            DLD_DECIDE:
            begin
                n.dir_en = dir_en_c;
                n.blk    = blk_c;
                n.angle  = ang_c;
                n.src    = src_c;
                // The scan winner moves during a scan, so status shows it held.
                n.sel    = q.best; // RQ1
                n.dir_ok = !blk_c && (q.sotf_s || non_directional_c // RQ13 RQ16
                           || (dir_en_c && in_win)); // RQ7 RQ18
                n.rel    = q.en && !blk_c && (q.sotf_s || non_directional_c
                           || (dir_en_c && in_win)); // RQ19
                n.st       = DLD_SCAN;
                n.idx      = 3'h0;
                n.found    = 1'b0;
                n.best     = 3'h0;
                n.best_uok = 1'b0;
                n.iso_l    = q.iso; // RQ3
            end
            default: n.st = DLD_SCAN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q       <= '0;
            q.st    <= DLD_SCAN;
            q.dir   <= DLD_DIR_FWD; // RQ10
            q.en    <= DLD_EN_RST;
            q.roa   <= DLD_ROA_RST; // RQ8
            q.rca   <= DLD_RCA_RST; // RQ9
            q.u_rat <= DLD_URAT_RST;
            q.i_rat <= DLD_IRAT_RST;
            q.src   <= DLD_SRC_NONE;
        end
        else
            q <= n;
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign direction_ok = q.dir_ok;
    assign oc_release   = q.rel;
    assign oc_current   = q.oc_cur;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_scan;
        (q.st == DLD_SCAN) [*6] ##1 (q.st == DLD_DECIDE);
    endsequence

    property p_scan;
        (q.st == DLD_DECIDE) |=> s_scan;
    endproperty
    a_scan: assert property (p_scan) // RQ1
        else $error("Loop scan did not take six cycles.");

    property p_iso;
        (q.st == DLD_DECIDE && q.found && q.iso_l) |-> (q.best < 3'h3);
    endproperty
    a_iso: assert property (p_iso) // RQ3
        else $error("Isolated network chose a ground loop.");

    property p_sotf;
        (q.st == DLD_DECIDE && q.sotf_s && !blk_c)
            |=> direction_ok && oc_release == $past(q.en);
    endproperty
    a_sotf: assert property (p_sotf) // RQ13
        else $error("Switch-onto-fault did not force direction.");

    property p_block;
        (q.st == DLD_DECIDE && q.vtf_s && !q.vtnd)
            |=> !direction_ok && !oc_release;
    endproperty
    a_block: assert property (p_block) // RQ15
        else $error("VT failure did not block the function.");

    property p_non_directional;
        (q.st == DLD_DECIDE && !blk_c && (q.dir == DLD_DIR_NON_DIRECTIONAL
            || (q.vtf_s && q.vtnd))) |=> direction_ok;
    endproperty
    a_non_directional: assert property (p_non_directional) // RQ16 RQ14
        else $error("Non-directional mode gave false direction.");

    property p_enable;
        (q.st == DLD_DECIDE && !dir_en_c && !q.sotf_s && !non_directional_c)
            |=> !direction_ok ##1 $stable(direction_ok);
    endproperty
    a_enable: assert property (p_enable) // RQ5
        else $error("Direction true without level enable.");

    property p_release;
        oc_release |-> direction_ok;
    endproperty
    a_release: assert property (p_release) // RQ19
        else $error("Overcurrent released without direction.");

    property p_range;
        q.roa >= DLD_ROA_MIN && q.roa <= DLD_ROA_MAX
            && q.rca >= DLD_RCA_MIN && q.rca <= DLD_RCA_MAX;
    endproperty
    a_range: assert property (p_range) // RQ8
        else $error("Angle setting out of range.");

    property p_route;
        ##1 1'b1 |-> oc_current == ($past(q.rms) ? $past(i_rms)
                                                 : $past(i_fund));
    endproperty
    a_route: assert property (p_route) // RQ17
        else $error("Wrong current routed to overcurrent stage.");

    property p_apb;
        (psel && !penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("APB answer not one cycle after setup.");
endmodule // dld_directional_loop_decision

// file: logic/dld_pkg.sv
// Constants, register layout and angle helpers of the directional loop decision.
// Assumes magnitudes are unsigned and angles are signed whole degrees.
package dld_pkg;
    localparam int          DLD_W       = 16;
    localparam int          DLD_AW      = 10;
    localparam int          DLD_NLOOP   = 6;
    localparam int          DLD_NPP     = 3;
    localparam logic [11:0] DLD_OFF_CTRL   = 12'h000;
    localparam logic [11:0] DLD_OFF_ANGLE  = 12'h004;
    localparam logic [11:0] DLD_OFF_RATED  = 12'h008;
    localparam logic [11:0] DLD_OFF_STATUS = 12'h00C;
    localparam int          DLD_CTL_ISO  = 0;
    localparam int          DLD_CTL_DIR  = 1;
    localparam int          DLD_CTL_VTND = 3;
    localparam int          DLD_CTL_RMS  = 4;
    localparam int          DLD_CTL_UINV = 5;
    localparam int          DLD_CTL_IINV = 6;
    localparam int          DLD_CTL_EN   = 7;
    localparam logic        DLD_EN_RST   = 1'h1;
    localparam logic [1:0]  DLD_DIR_FWD    = 2'h0;
    localparam logic [1:0]  DLD_DIR_BWD    = 2'h1;
    localparam logic [1:0]  DLD_DIR_NON_DIRECTIONAL = 2'h2;
    localparam int          DLD_ROA_LSB = 0;
    localparam int          DLD_RCA_LSB = 16;
    localparam logic [6:0]  DLD_ROA_MIN = 7'h0A;
    localparam logic [6:0]  DLD_ROA_MAX = 7'h55;
    localparam logic [6:0]  DLD_ROA_RST = 7'h3C;
    localparam logic signed [7:0] DLD_RCA_MIN = 8'hA6;
    localparam logic signed [7:0] DLD_RCA_MAX = 8'h5A;
    localparam logic signed [7:0] DLD_RCA_RST = 8'h3C;
    localparam int          DLD_URAT_LSB = 0;
    localparam int          DLD_IRAT_LSB = 16;
    localparam logic [15:0] DLD_URAT_RST = 16'h1000;
    localparam logic [15:0] DLD_IRAT_RST = 16'h1000;
    localparam int          DLD_ST_OK    = 0;
    localparam int          DLD_ST_EN    = 1;
    localparam int          DLD_ST_LOOP  = 2;
    localparam int          DLD_ST_SRC   = 5;
    localparam int          DLD_ST_BLK   = 7;
    localparam int          DLD_ST_ANG   = 8;
    localparam logic [1:0]  DLD_SRC_LOOP = 2'h0;
    localparam logic [1:0]  DLD_SRC_POS  = 2'h1;
    localparam logic [1:0]  DLD_SRC_MEM  = 2'h2;
    localparam logic [1:0]  DLD_SRC_NONE = 2'h3;
    localparam int          DLD_U_MIN_PCT = 5;
    localparam int          DLD_I_MIN_PCT = 8;
    localparam int          DLD_PCT_FULL  = 100;
    localparam logic signed [11:0] DLD_HALF = 12'h0B4;
    localparam logic signed [11:0] DLD_FULL = 12'h168;

    // Folds any sum of two angles back into -180 to 179 degrees.
    function automatic logic signed [DLD_AW-1:0] dld_wrap(
        input logic signed [11:0] a);
        logic signed [11:0] r;
        r = a;
        if (r >= DLD_HALF)
            r = r - DLD_FULL;
        if (r >= DLD_HALF)
            r = r - DLD_FULL;
        if (r < -DLD_HALF)
            r = r + DLD_FULL;
        if (r < -DLD_HALF)
            r = r + DLD_FULL;
        return r[DLD_AW-1:0];
    endfunction
endpackage

// file: logic/dld_loop_qualify.sv
// Level check of loop voltages and currents against the rated values.
// Assumes magnitudes and rated values share one scale on the same clock.
`timescale 1ns/1ps
module dld_loop_qualify
    import dld_pkg::*;
#(
    parameter int N = DLD_NLOOP
)(
    input  wire logic [N-1:0][DLD_W-1:0] u_mag,
    input  wire logic [N-1:0][DLD_W-1:0] i_mag,
    input  wire logic [DLD_W-1:0]        u_rated,
    input  wire logic [DLD_W-1:0]        i_rated,
    output logic      [N-1:0]            u_ok,
    output logic      [N-1:0]            i_ok
);
    logic [31:0] u_lim;
    logic [31:0] i_lim;

    if (N < 1)
    begin : g_bad_n
        $error("dld_loop_qualify needs at least one loop.");
    end

    // Scaling by a hundred avoids a divider for the percentages.
    assign u_lim = 32'(u_rated) * 32'(DLD_U_MIN_PCT);
    assign i_lim = 32'(i_rated) * 32'(DLD_I_MIN_PCT);

    for (genvar k = 0; k < N; k++)
    begin : g_loop
        assign u_ok[k] = 32'(u_mag[k]) * 32'(DLD_PCT_FULL) > u_lim;
        assign i_ok[k] = 32'(i_mag[k]) * 32'(DLD_PCT_FULL) >= i_lim;
    end
endmodule // dld_loop_qualify

// file: logic/dld_angle_window.sv
// Angle window test of the direction decision.
// Assumes angles in whole degrees, the current being the reference.
`timescale 1ns/1ps
module dld_angle_window
    import dld_pkg::*;
(
    input  wire logic signed [DLD_AW-1:0] angle,
    input  wire logic signed [7:0]        rca,
    input  wire logic [6:0]               roa,
    input  wire logic                     backward,
    input  wire logic                     flip,
    output logic                          in_win
);
    logic signed [11:0]       rot;
    logic signed [DLD_AW-1:0] centre;
    logic signed [DLD_AW-1:0] dev;
    logic [DLD_AW-1:0]        mag;

    // Reversed polarity and backward sense each turn the window over.
    assign rot    = (backward ^ flip) ? DLD_HALF : 12'h000;
    assign centre = dld_wrap(12'(rca) + rot); // RQ20 RQ10
    assign dev    = dld_wrap(12'(angle) - 12'(centre));
    assign mag    = dev[DLD_AW-1] ? DLD_AW'(-dev) : DLD_AW'(dev);
    assign in_win = mag <= DLD_AW'(roa); // RQ7 RQ20
endmodule // dld_angle_window

// file: verification/dld_oc_stage_model.sv
// Overcurrent stage model that sits behind the directional front end.
// Assumes the front end's clock and active-low reset.
`timescale 1ns/1ps
module dld_oc_stage_model
    import dld_pkg::*;
#(
    parameter logic [15:0] LEVEL = 16'h0100
)(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  release_in,
    input  wire logic [2:0][DLD_W-1:0] cur,
    output logic                       start
);
    // Starts only while released and at least one phase current is above LEVEL.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start <= 1'h0;
        else
            start <= release_in & ((cur[0] > LEVEL) | (cur[1] > LEVEL)
                     | (cur[2] > LEVEL));
    end
endmodule // dld_oc_stage_model

// file: verification/tb_top.sv
// Self-checking bench of the directional loop decision block.
// Assumes an APB slave on pclk and a 7-cycle decision period.
`timescale 1ns/1ps
module tb_top
    import dld_pkg::*;
;
    localparam int HU = 16'h0800;
    localparam int HI = 16'h0F00;
    localparam int LU = 16'h0010;
    logic                  pclk, presetn, psel, penable, pwrite, pready;
    logic                  pslverr, sotf, vtf, direction_ok, oc_release, start;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, r, seed;
    logic                  e;
    logic [5:0][15:0]      lum, lim;
    logic [5:0][9:0]       lua, lia;
    logic [15:0]           pum;
    logic [9:0]            pua;
    logic [2:0][15:0]      ifd, irm, occ;
    int                    err_total, checks_done, i, k, a, o, q, ero, erc;
    int                    ro[6] = '{9, 10, 86, 85, 60, 60};
    int                    rc[6] = '{0, -90, 91, 90, -91, 60};
    dld_directional_loop_decision dld_directional_loop_decision_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_u_mag(lum), .loop_u_ang(lua), .loop_i_mag(lim),
        .loop_i_ang(lia), .pos_u_mag(pum), .pos_u_ang(pua), .i_fund(ifd),
        .i_rms(irm), .switch_onto_fault_cond(sotf),
        .vt_supervision_fail(vtf), .direction_ok(direction_ok),
        .oc_release(oc_release), .oc_current(occ));
    dld_oc_stage_model dld_oc_stage_model_inst (.pclk(pclk),
        .presetn(presetn), .release_in(oc_release), .cur(occ), .start(start));
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic inwin(int x, int c, int w, logic b);
        int d;
        d = x - c - (b ? 180 : 0);
        while (d >= 180)
            d -= 360;
        while (d < -180)
            d += 360;
        return (d <= w) && (d >= -w);
    endfunction
    function automatic logic [31:0] ang(int w, int c);
        return {8'h00, 8'(c), 9'h000, 7'(w)};
    endfunction
    task summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(string n, logic [47:0] x, logic [47:0] s);
        checks_done++;
        if (s !== x)
        begin
            $display("BAD %s expected %h seen %h", n, x, s);
            err_total++;
        end
    endtask
    task apb(logic w, logic [11:0] ad, logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50)
            err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task run(int t, int ua, int um, int im, int ub, int pm,
             logic [31:0] c, logic [31:0] g, logic [1:0] p, logic ok,
             int el, int es);
        logic [2:0][15:0] f, m, s;
        f = {16'(rnd()), 16'(rnd()), 16'(rnd())};
        m = {16'(rnd()), 16'(rnd()), 16'(rnd())};
        s = c[4] ? m : f;
        @(posedge pclk);
        for (int j = 0; j < 6; j++)
        begin
            lum[j] <= 16'((j == t) ? um : ub);
            lim[j] <= 16'((j == t || im < 16'h0200) ? im : 16'h0400);
            lua[j] <= 10'((j == t) ? ua : 0);
            lia[j] <= 10'h000;
        end
        pum <= 16'(pm);
        ifd <= f;
        irm <= m;
        sotf <= p[0];
        vtf <= p[1];
        apb(1'h1, DLD_OFF_CTRL, c);
        apb(1'h1, DLD_OFF_ANGLE, g);
        repeat (21) @(posedge pclk);
        chk("direction_ok", ok, direction_ok);
        chk("oc_release", ok & c[7], oc_release);
        chk("oc_current", s, occ);
        chk("start", ok & c[7] & ((s[0] > 16'h0100) | (s[1] > 16'h0100)
            | (s[2] > 16'h0100)), start);
        apb(1'h0, DLD_OFF_STATUS, 32'h0);
        if (el >= 0)
            chk("loop", el, r[4:2]);
        if (es >= 0)
            chk("source", es, r[6:5]);
        chk("blocked", p[1] & ~c[3], r[7]);
        $display("test done at %0t", $time);
    endtask
    initial
    begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        summarize();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sotf, vtf} = '0;
        {lum, lim, lua, lia, pum, pua, ifd, irm} = '0;
        {err_total, checks_done, ero, erc} = '0;
        seed = 32'h87AF0D21;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, DLD_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h80, r);
        apb(1'h0, DLD_OFF_ANGLE, 32'h0);
        chk("angle", 32'h003C003C, r);
        apb(1'h0, 12'h010, 32'h0);
        chk("slverr", 1'h1, e);
        ero = 60;
        erc = 60;
        for (i = 0; i < 6; i++)
        begin
            apb(1'h1, DLD_OFF_ANGLE, ang(ro[i], rc[i]));
            if (ro[i] >= 10 && ro[i] <= 85)
                ero = ro[i];
            if (rc[i] >= -90 && rc[i] <= 90)
                erc = rc[i];
            apb(1'h0, DLD_OFF_ANGLE, 32'h0);
            chk("angle", ang(ero, erc), r);
        end
        for (i = 0; i < 12; i++)
        begin
            k = rnd() % 6;
            a = int'(rnd() % 360) - 180;
            o = 10 + int'(rnd() % 76);
            q = int'(rnd() % 181) - 90;
            r = 32'h80 | (rnd() & 32'h62);
            run(k, a, HU, HI, HU, HU, r, ang(o, q), 2'h0,
                inwin(a, q, o, r[1] ^ r[5] ^ r[6]), k, 0);
        end
        run(4, -120, HU, HI, HU, HU, 32'h81, ang(60, 60), 2'h0, 1, 0, 0);
        run(2, -120, 256, 320, HU, HU, 32'h80, ang(60, 60), 2'h0, 0, 0, 0);
        run(2, -120, 256, 336, HU, HU, 32'h80, ang(60, 60), 2'h0, 0, 2, 0);
        run(1, 60, HU, 256, HU, HU, 32'h80, ang(60, 60), 2'h0, 0, -1, -1);
        run(0, -120, HU, HI, HU, HU, 32'h80, ang(10, 60), 2'h1, 1, 0, 0);
        run(0, -120, HU, HI, HU, HU, 32'h88, ang(10, 60), 2'h2, 1, 0, 0);
        run(0, 60, HU, HI, HU, HU, 32'h80, ang(10, 60), 2'h2, 0, 0, 0);
        run(5, -120, HU, HI, HU, HU, 32'h84, ang(10, 60), 2'h0, 1, 5, 0);
        run(5, 60, HU, HI, HU, HU, 32'h14, ang(10, 60), 2'h0, 1, 5, 0);
        run(3, 0, LU, HI, LU, HU, 32'h84, ang(60, 60), 2'h0, 1, 3, 1);
        run(3, 0, LU, HI, LU, LU, 32'h84, ang(60, 60), 2'h0, 1, 3, 2);
        summarize();
    end
endmodule // tb_top
